// file: pbps_pkg.sv
// package: timing constants and signal bundles for the power sequencer
package pbps_pkg;
   localparam int unsigned CLK_HZ = 40000000; // block clock rate
   localparam int unsigned TICK_MS = 1; // tick period in ms
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned DEBOUNCE_MS = 32; // on and off debounce
   localparam int unsigned GRACE_MS = 512; // startup grace window
   localparam int unsigned FIXED_PD_MS = 64; // fixed power-down delay
   localparam int unsigned MIN_ALERT_MS = 32; // least alert pulse
   localparam int unsigned HOLD_MS = 200; // supervisor hold delay
   localparam int unsigned EXTRA_DEFAULT_MS = 16; // extra delay default
   localparam int unsigned CNT_W = 12; // ms counter width
   // raw pin inputs, all active as named
   typedef struct packed {
      logic button_n;
      logic lockout_supply_low;
      logic load_supply_monitor_low;
      logic kill_n;
   } pins_type;
endpackage : pbps_pkg

// file: tick_gen.sv
// tick_gen: divides the block clock into a one-cycle tick pulse
`timescale 1ns/10ps
module tick_gen #(
   parameter int unsigned DIVIDE = pbps_pkg::TICK_CYCLES
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   output logic tick_o
);
   logic [31:0] count; // cycles since last tick
   logic last; // terminal count reached
   assign last = (count == DIVIDE - 1);
   // free-running divider, pulse on wrap
   always_ff @(posedge mclk_i) begin
      if (rst_i || last) begin
         count <= 32'h0;
      end else begin
         count <= count + 32'h1;
      end
   end
   // tick is a registered copy of the wrap
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         tick_o <= 1'b0;
      end else begin
         tick_o <= last;
      end
   end
endmodule : tick_gen

// file: push_button_power_sequencer.sv
// push_button_power_sequencer: power on/off control from a push button
`timescale 1ns/10ps
module push_button_power_sequencer #(
   parameter int unsigned TICK_DIVIDE = pbps_pkg::TICK_CYCLES,
   parameter int unsigned DEBOUNCE_MS = pbps_pkg::DEBOUNCE_MS,
   parameter int unsigned GRACE_MS = pbps_pkg::GRACE_MS,
   parameter int unsigned FIXED_PD_MS = pbps_pkg::FIXED_PD_MS,
   parameter int unsigned MIN_ALERT_MS = pbps_pkg::MIN_ALERT_MS,
   parameter int unsigned HOLD_MS = pbps_pkg::HOLD_MS,
   parameter bit ACTIVE_LOW_SWITCH = 1'b0
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire pbps_pkg::pins_type pins_i,
   input wire logic early_warning_in_low_i,
   input wire logic [pbps_pkg::CNT_W-1:0] extra_delay_timer_i,
   output logic power_switch_o,
   output logic host_alert_n_o,
   output logic early_warning_out_n_o,
   output logic supervisor_hold_n_o
);
   localparam int W = pbps_pkg::CNT_W;
   typedef enum logic [2:0] {
      OFF, ON_DEB, GRACE, RUN, ALERT, SPENT
   } state_type;

   // three-stage synchronisers per pin
   pbps_pkg::pins_type s1, s2, s3, clean;
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s1 <= 4'hD;
         s2 <= 4'hD;
         s3 <= 4'hD;
      end else begin
         s1 <= pins_i;
         s2 <= s1;
         s3 <= s2;
      end
   end
   // accept a level once the second and third stages agree
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         clean <= 4'hD;
      end else begin
         clean <= ((s2 ~^ s3) & s2) | (~(s2 ~^ s3) & clean);
      end
   end

   logic tick; // 1ms enable
   tick_gen #(.DIVIDE(TICK_DIVIDE)) u_tick (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .tick_o(tick)
   );

   state_type state, next_state; // sequencer state
   logic [W-1:0] tmr; // ms in current low/phase
   logic [W-1:0] alert_ms; // ms since alert asserted
   logic [W-1:0] hold_ms; // ms of good supply
   logic owner_btn; // button owns power-down
   logic pwr_on; // system power on
   logic alert; // alert asserted
   logic hold; // supervisor hold asserted

   // decoded input levels
   wire btn_low = ~clean.button_n;
   wire lock_low = clean.lockout_supply_low;
   wire kill_low = ~clean.kill_n;
   wire src_low = owner_btn ? btn_low : lock_low;
   wire any_low = btn_low | lock_low;
   wire [W-1:0] forced_ms = W'(FIXED_PD_MS) + extra_delay_timer_i;
   wire deb_done = (tmr >= W'(DEBOUNCE_MS));
   wire grace_done = (tmr >= W'(GRACE_MS));
   wire forced_done = (tmr >= forced_ms);
   wire min_alert_met = (alert_ms >= W'(MIN_ALERT_MS));

   // sequencer transitions
   always_comb begin
      next_state = state;
      case (state)
         OFF: begin
            if (btn_low && !lock_low) begin
               next_state = ON_DEB;
            end
         end
         ON_DEB: begin
            if (!btn_low || lock_low) begin
               next_state = OFF;
            end else if (deb_done) begin
               next_state = GRACE;
            end
         end
         GRACE: begin
            if (!kill_low) begin
               next_state = btn_low ? SPENT : RUN;
            end else if (grace_done) begin
               next_state = OFF;
            end
         end
         RUN: begin
            if (kill_low) begin
               next_state = OFF;
            end else if (src_low && deb_done) begin
               next_state = ALERT;
            end
         end
         ALERT: begin
            // owner still low past fixed plus extra delay: forced off
            if (src_low && forced_done) begin
               next_state = OFF;
            end else if (kill_low) begin
               next_state = OFF;
            end else if (!src_low && min_alert_met) begin
               next_state = RUN;
            end
         end
         SPENT: begin
            // wait for release of the button that turned power on
            if (kill_low) begin
               next_state = OFF;
            end else if (!btn_low) begin
               next_state = RUN;
            end
         end
         default: begin
            next_state = OFF;
         end
      endcase
   end

   // the timer runs on from RUN into ALERT so the forced delay is
   // measured from the start of the owner's low level
   wire clear_tmr = ((next_state != state) &&
                     !(state == RUN && next_state == ALERT)) ||
                    (state == RUN && !src_low) ||
                    (state == ALERT && !src_low);

   // state, ownership and ms timer
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state <= OFF;
         tmr <= '0;
         owner_btn <= 1'b1;
      end else begin
         state <= next_state;
         if (clear_tmr) begin
            tmr <= '0;
         end else if (tick && tmr != '1) begin
            tmr <= tmr + 1'b1;
         end
         if (state == RUN && !any_low) begin
            owner_btn <= 1'b1;
         end else if (state == RUN && !src_low) begin
            // owner idle, other source low: it takes ownership
            owner_btn <= btn_low;
         end
      end
   end

   // alert pulse width counter
   always_ff @(posedge mclk_i) begin
      if (rst_i || state != ALERT) begin
         alert_ms <= '0;
      end else if (tick && alert_ms != '1) begin
         alert_ms <= alert_ms + 1'b1;
      end
   end

   assign pwr_on = (state == GRACE) || (state == RUN) ||
                   (state == ALERT) || (state == SPENT);
   assign alert = (state == ALERT);

   // registered power and alert outputs
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         power_switch_o <= ACTIVE_LOW_SWITCH;
         host_alert_n_o <= 1'b1;
      end else begin
         power_switch_o <= ACTIVE_LOW_SWITCH ^ pwr_on;
         host_alert_n_o <= ~alert;
      end
   end

   // comparator passes straight through, no timing
   assign early_warning_out_n_o = ~early_warning_in_low_i;

   // supervisor hold: drop with monitor, release after good time
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         hold_ms <= '0;
         hold <= 1'b1;
      end else if (clean.load_supply_monitor_low) begin
         hold_ms <= '0;
         hold <= 1'b1;
      end else if (hold && tick) begin
         hold_ms <= hold_ms + 1'b1;
         if (hold_ms + 1'b1 >= W'(HOLD_MS)) begin
            hold <= 1'b0;
         end
      end
   end
   assign supervisor_hold_n_o =
      ~(hold | clean.load_supply_monitor_low);

   // assertions
   AST_WARN_PASS: assert property (@(posedge mclk_i)
      early_warning_out_n_o == !early_warning_in_low_i)
      else $error("early warning not passed through");
   AST_HOLD_FALL: assert property (@(posedge mclk_i) disable iff (rst_i)
      clean.load_supply_monitor_low |-> !supervisor_hold_n_o)
      else $error("hold not low with monitor low");
   AST_LOCK_BLOCK: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state == OFF && lock_low) |=> state == OFF)
      else $error("power-on started under lockout");
   AST_KILL_OFF: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state == RUN && kill_low) |=> ##1 power_switch_o == ACTIVE_LOW_SWITCH)
      else $error("kill did not remove power");
   AST_GRACE_ABORT: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state == GRACE && kill_low && grace_done) |=> state == OFF)
      else $error("grace expiry did not abort");
   AST_GRACE_IGNORE: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state == GRACE && kill_low && !grace_done) |=> state == GRACE)
      else $error("low kill acted during grace");
   AST_ON_DEB: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state == ON_DEB && $changed(state) == 0 && next_state == GRACE)
      |-> tmr >= W'(DEBOUNCE_MS))
      else $error("power-on before debounce");
   AST_ALERT_MIN: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state == ALERT && next_state == RUN) |-> alert_ms >= W'(MIN_ALERT_MS))
      else $error("alert shorter than minimum");
   AST_ALERT_DEB: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state == RUN && next_state == ALERT) |-> tmr >= W'(DEBOUNCE_MS))
      else $error("alert before debounce");
   AST_FORCED: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state == ALERT && src_low && forced_done) |=> state == OFF)
      else $error("forced off not taken");
   // entry into the power-on grace window
   sequence grace_entry_seq;
      state == ON_DEB ##1 state == GRACE;
   endsequence
   // entry into the alert phase from normal running
   sequence alert_entry_seq;
      state == RUN ##1 state == ALERT;
   endsequence
   AST_SWITCH_ON: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      grace_entry_seq |=> power_switch_o != ACTIVE_LOW_SWITCH)
      else $error("switch not on after debounce");
   AST_FORCED_SPAN: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      alert_entry_seq |-> tmr >= W'(DEBOUNCE_MS))
      else $error("forced timer restarted at alert");
   AST_OWNER_HOLD: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      ((state == RUN && src_low) || state == ALERT) |=> $stable(owner_btn))
      else $error("ownership changed during sequence");
   AST_HOLD_RELEASE: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      $fell(hold) |-> hold_ms == W'(HOLD_MS))
      else $error("hold released before good time");
   AST_SWITCH_POL: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (state == OFF && $past(state) == OFF) |->
      power_switch_o == ACTIVE_LOW_SWITCH)
      else $error("switch not at off level");
   AST_RESET_CLEAR: assert property (
      @(posedge mclk_i) rst_i |=> state == OFF && tmr == '0 && hold &&
      power_switch_o == ACTIVE_LOW_SWITCH && host_alert_n_o)
      else $error("reset left state behind");
endmodule : push_button_power_sequencer

// file: host_model.sv
// host_model: host processor answering the power-off handshake
`timescale 1ns/10ps
module host_model #(
   parameter int MS = 4
) (
   input wire logic mclk_i,
   input wire logic power_on_i,
   input wire logic host_alert_n_i,
   input wire logic [15:0] boot_ms_i,
   input wire logic [15:0] kill_ms_i,
   output logic kill_n_o = 1'b0
);
   int boot_cnt = 0; // cycles since power came up
   int kill_cnt = 0; // cycles since the alert was seen
   bit seen = 1'b0; // alert seen while powered
   // unpowered host holds the off request low
   always @(posedge mclk_i) begin
      if (!power_on_i) begin
         kill_n_o <= 1'b0;
         boot_cnt <= 0;
         kill_cnt <= 0;
         seen <= 1'b0;
      end else begin
         boot_cnt <= boot_cnt + 1;
         // raise the request line once booted, zero means never
         if (boot_ms_i != 16'h0000 && boot_cnt == boot_ms_i * MS)
            kill_n_o <= 1'b1;
         if (!host_alert_n_i)
            seen <= 1'b1;
         if (seen || !host_alert_n_i)
            kill_cnt <= kill_cnt + 1;
         // housekeeping done: drop the line to end power
         if (kill_cnt == kill_ms_i * MS)
            kill_n_o <= 1'b0;
      end
   end
endmodule : host_model

// file: push_button_power_sequencer_tb.sv
// push_button_power_sequencer_tb: self-checking bench for the sequencer
`timescale 1ns/10ps
module push_button_power_sequencer_tb;
   localparam int MS = 4; // cycles per ms tick
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic btn_n = 1'b1, lock = 1'b0, mon = 1'b0, ew = 1'b0;
   logic kill_n;
   logic [11:0] extra = 12'h008;
   logic [15:0] boot_ms = 16'h0000, kill_ms = 16'h0028;
   pbps_pkg::pins_type pins;
   logic sw, alert_n, ew_n, hold_n;
   logic sw_low; // switch of the active-low build
   int fail_count = 0, comparisons = 0, seed = 96, e = 8;
   assign pins = {btn_n, lock, mon, kill_n};
   push_button_power_sequencer #(.TICK_DIVIDE(MS))
      u_push_button_power_sequencer (
      .mclk_i(mclk_i), .rst_i(rst_i), .pins_i(pins),
      .early_warning_in_low_i(ew), .extra_delay_timer_i(extra),
      .power_switch_o(sw), .host_alert_n_o(alert_n),
      .early_warning_out_n_o(ew_n), .supervisor_hold_n_o(hold_n));
   // second copy in the active-low switch build, same inputs
   push_button_power_sequencer #(.TICK_DIVIDE(MS), .ACTIVE_LOW_SWITCH(1'b1))
      u_push_button_power_sequencer_low (
      .mclk_i(mclk_i), .rst_i(rst_i), .pins_i(pins),
      .early_warning_in_low_i(ew), .extra_delay_timer_i(extra),
      .power_switch_o(sw_low), .host_alert_n_o(),
      .early_warning_out_n_o(), .supervisor_hold_n_o());
   host_model #(.MS(MS)) u_host_model (.mclk_i(mclk_i), .power_on_i(sw),
      .host_alert_n_i(alert_n), .boot_ms_i(boot_ms), .kill_ms_i(kill_ms),
      .kill_n_o(kill_n));
   // 40 MHz clock
   initial begin
      forever #12.5 mclk_i = ~mclk_i;
   end
   // compare one value
   task check(input logic seen, input logic exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %0t: saw %b expected %b", $time, seen, exp);
      end
   endtask : check
   // step n cycles, landing just after the edge
   task tick(input int n);
      repeat (n) @(posedge mclk_i);
      #2;
   endtask : tick
   // selected output: 0 switch, 1 alert, 2 hold
   function logic pick(input int sel);
      return sel == 0 ? sw : sel == 1 ? alert_n : hold_n;
   endfunction : pick
   // wait for an output level, inside a window of cycles
   task wait_for(input int sel, input logic val, input int lo, input int hi);
      int n;
      n = 0;
      while (pick(sel) !== val && n <= hi) begin
         tick(1);
         n++;
      end
      if (n > hi) begin
         fail_count++;
         $display("Error %0t: wait on output %0d ran out", $time, sel);
         complete_run();
      end
      check(n >= lo, 1'b1);
      if (sel == 0) check(sw_low, ~val);
   endtask : wait_for
   // press for power-on, release, sit out the grace window
   task power_on;
      btn_n = 1'b0;
      wait_for(0, 1'b1, 31 * MS, 33 * MS + 12);
      btn_n = 1'b1;
      tick(520 * MS);
   endtask : power_on
   // verdict
   task complete_run;
      $display("checks %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run
   // main sequence
   initial begin
      tick(8);
      rst_i = 1'b0;
      check(sw, 1'b0);
      check(sw_low, 1'b1);
      check(alert_n, 1'b1);
      check(hold_n, 1'b0);
      repeat (16) begin
         ew = 1'($random(seed));
         #1 check(ew_n, ~ew);
         tick(1);
      end
      $display("test warning done");
      mon = 1'b1;
      tick(6);
      check(hold_n, 1'b0);
      mon = 1'b0;
      tick(100 * MS);
      mon = 1'b1;
      tick(6);
      mon = 1'b0;
      wait_for(2, 1'b1, 199 * MS, 201 * MS + 12);
      // hold now released: a new drop pulls it low four cycles later, not two
      mon = 1'b1;
      tick(2);
      check(hold_n, 1'b1);
      tick(2);
      check(hold_n, 1'b0);
      mon = 1'b0;
      $display("test supervisor done");
      btn_n = 1'b0;
      wait_for(0, 1'b1, 31 * MS, 33 * MS + 12);
      btn_n = 1'b1;
      wait_for(0, 1'b0, 510 * MS, 513 * MS + 12);
      $display("test abort done");
      boot_ms = 16'h0064;
      power_on();
      btn_n = 1'b0;
      wait_for(1, 1'b0, 31 * MS, 33 * MS + 12);
      tick(8 * MS);
      btn_n = 1'b1;
      wait_for(1, 1'b1, 22 * MS, 26 * MS + 12);
      check(sw, 1'b1);
      wait_for(0, 1'b0, 0, 20 * MS);
      $display("test interrupt done");
      e = 4 + ($random(seed) & 7);
      extra = 12'(e);
      kill_ms = 16'h03E8;
      power_on();
      btn_n = 1'b0;
      wait_for(0, 1'b0, (63 + e) * MS, (65 + e) * MS + 16);
      check(alert_n, 1'b1);
      btn_n = 1'b1;
      $display("test forced done");
      power_on();
      lock = 1'b1;
      // a short press while the lockout owns the sequence is ignored
      tick(10 * MS);
      btn_n = 1'b0;
      tick(10 * MS);
      btn_n = 1'b1;
      wait_for(1, 1'b0, 11 * MS, 13 * MS + 12);
      ew = 1'b1;
      #1 check(alert_n | ew_n, 1'b0);
      wait_for(0, 1'b0, (31 + e) * MS, (33 + e) * MS + 16);
      check(alert_n, 1'b1);
      btn_n = 1'b0;
      tick(40 * MS);
      check(sw, 1'b0);
      $display("test lockout done");
      complete_run();
   end
endmodule : push_button_power_sequencer_tb
